// ---- colour_gate.v ----
// colour decoder and per-channel on/off video gating with output fifo
// Operation
// - highlight flags, selector intermediates, colour attributes give active-low invert and force
// - covering cursor position drives all three invert signals low
// - sweep zero of message line drives blue invert low
// - transparent cursor: force low where that channel's colour attribute is low
// - ordinary positions: invert and force follow colour attributes and selector intermediates
// - presentation on only with enable high, inhibit 0, enable bit 1, load low
// - cursor style bit one selects transparent cursor, zero selects covering
// - cursor position input is high only at the cursor's character
// - invert level chooses true or complemented final video
// - force high fixes output: on with invert low, off with invert high
// - force low: normal video with invert low, inverted video with invert high
// - neutral low: each channel fed only from its own generator block
// - triple-plane presentation holds all three block selects high
// - neutral high: same video to all channels, colour from force and invert
// - in single-plane mode a high block select marks the working block
// - block selects come from the address rom with unchanged polarity
// - neutral low whenever triple-plane addressing and video on
`timescale 1ns/10ps
`include "colour_gate_defs.vh"
module colour_gate (
  input  wire                  mclk_i,
  input  wire                  rstn_i,
  // register port
  input  wire [`ADDR_W-1:0]    reg_addr_i,
  input  wire [`DATA_W-1:0]    reg_wdata_i,
  input  wire                  reg_wr_i,
  input  wire                  reg_rd_i,
  output reg  [`DATA_W-1:0]    reg_rdata_o,
  // one character pixel of upstream decoder results
  input  wire                  pix_valid_i,
  output wire                  pix_ready_o,
  input  wire                  double_sweep_flag_i,
  input  wire                  sweep_zero_flag_i,
  input  wire                  underline_sweep_flag_i,
  input  wire                  selector_mid_two_i,
  input  wire                  selector_mid_one_i,
  input  wire                  selector_mid_s_n_i,
  input  wire                  attr_blue_n_i,
  input  wire                  attr_red_n_i,
  input  wire                  attr_green_n_i,
  input  wire                  display_enable_i,
  input  wire                  vsync_load_n_i,
  input  wire                  cursor_position_i,
  input  wire                  triple_plane_i,
  input  wire                  video_on_n_i,
  input  wire                  rom_blue_block_sel_i,
  input  wire                  rom_red_block_sel_i,
  input  wire                  rom_green_block_sel_i,
  input  wire                  cg_blue_video_i,
  input  wire                  cg_red_video_i,
  input  wire                  cg_green_video_i,
  // gated colour video towards the monitor
  output reg                   blue_video_out_o,
  output reg                   red_video_out_o,
  output reg                   green_video_out_o,
  output reg                   video_valid_o,
  input  wire                  video_ready_i
);

  // control register and software-visible counter
  reg  [`CTRL_W-1:0]           ctrl;
  reg  [`PIXCNT_W-1:0]         pix_count;

  // decoded per-pixel conditions
  wire                         cursor_style_bit;
  wire                         presentation_inhibit_bit;
  wire                         presentation_enable_bit;
  wire                         presentation_on_n;
  wire                         transparent_cursor_sel;
  wire                         neutral_sel;
  wire                         base_cond;
  wire                         cov_cursor;
  wire                         msg_sweep0;
  wire [`CH_N-1:0]             attr_n;
  wire [`CH_N-1:0]             block_sel;
  wire [`CH_N-1:0]             cg_video;
  wire [`CH_N-1:0]             invert_n;
  wire [`CH_N-1:0]             force_n;
  wire [`CH_N-1:0]             gated_video;
  wire                         any_block_video;

  // snapshot of the last accepted decode, for software visibility
  reg  [`CH_N-1:0]             last_invert_n;
  reg  [`CH_N-1:0]             last_force_n;
  reg                          last_pres_on_n;
  reg                          last_neutral;

  // fifo side signals
  wire                         fifo_ready;
  wire [`CH_N-1:0]             fifo_data;
  wire                         fifo_valid;
  wire                         fifo_take;
  wire [`FIFO_AW:0]            fifo_level;
  wire                         pix_take;
  wire                         out_free;

  // control bit split
  assign cursor_style_bit         = ctrl[`CTRL_CURSOR_STYLE];
  assign presentation_inhibit_bit = ctrl[`CTRL_PRES_INHIBIT];
  assign presentation_enable_bit  = ctrl[`CTRL_PRES_ENABLE];

  // presentation qualifier is active low
  assign presentation_on_n = ~(display_enable_i & ~presentation_inhibit_bit
                               & presentation_enable_bit & ~vsync_load_n_i);

  // cursor style select straight from the control bit
  assign transparent_cursor_sel = cursor_style_bit;

  // neutral low means triple-plane stores feed the channels
  assign neutral_sel = ~(triple_plane_i & ~video_on_n_i);

  // pack channels as blue, red, green
  assign attr_n   = {attr_green_n_i, attr_red_n_i, attr_blue_n_i};
  assign cg_video = {cg_green_video_i, cg_red_video_i, cg_blue_video_i};

  // rom selects pass with their own polarity; triple-plane holds them high
  assign block_sel = {rom_green_block_sel_i, rom_red_block_sel_i, rom_blue_block_sel_i}
                     | {`CH_N{~neutral_sel}};

  // common terms shared by every row of the decode
  assign base_cond  = ~presentation_on_n & ~double_sweep_flag_i;
  // cursor position input marks only the addressed character
  assign cov_cursor = base_cond & ~sweep_zero_flag_i & cursor_position_i
                      & ~transparent_cursor_sel;
  assign msg_sweep0 = base_cond & sweep_zero_flag_i;

  // any working block's video, used only in single-plane mode
  assign any_block_video = |(cg_video & block_sel);

  // per-channel decode and gate, identical for all three colours except the blue-only sweep zero term
  genvar ch;
  generate
    for (ch = 0; ch < `CH_N; ch = ch + 1) begin : g_chan
      wire ord_inv;
      wire ord_force;
      wire tr_force;
      wire sweep_blue;
      wire src;

      // ordinary invert: colour attribute and both intermediates low
      assign ord_inv = base_cond & ~sweep_zero_flag_i & ~selector_mid_two_i
                       & ~selector_mid_one_i & ~attr_n[ch];

      // sweep zero drives invert low only on the blue channel
      assign sweep_blue = (ch == `CH_BLUE) ? msg_sweep0 : 1'b0;

      // invert drops low for covering cursor, sweep zero or colour
      assign invert_n[ch] = ~(cov_cursor | sweep_blue | ord_inv);

      // ordinary force: away from the cursor position
      assign ord_force = base_cond & ~sweep_zero_flag_i & ~underline_sweep_flag_i
                         & selector_mid_s_n_i & ~attr_n[ch] & ~cursor_position_i;

      // transparent cursor keeps the colour of the character
      assign tr_force  = base_cond & ~sweep_zero_flag_i & ~underline_sweep_flag_i
                         & selector_mid_s_n_i & ~attr_n[ch]
                         & transparent_cursor_sel;

      assign force_n[ch] = ~(ord_force | tr_force);

      // own block only in triple-plane, any working block in single-plane
      assign src = neutral_sel ? any_block_video
                               : (cg_video[ch] & block_sel[ch]);

      // final gate: force fixes the level, otherwise invert selects polarity
      assign gated_video[ch] = force_n[ch] ? ~invert_n[ch]
                                           : (src ^ invert_n[ch]);
    end
  endgenerate

  // the decode above is pure logic; the fifo write and the status snapshot register it
  assign pix_take    = pix_valid_i & fifo_ready;
  assign pix_ready_o = fifo_ready;

  // the fifo absorbs short stalls of the monitor side
  video_fifo #(
    .WIDTH (`CH_N),
    .DEPTH (`FIFO_DEPTH),
    .AW    (`FIFO_AW)
  ) u_fifo (
    .mclk_i     (mclk_i),
    .rstn_i     (rstn_i),
    .wr_data_i  (gated_video),
    .wr_valid_i (pix_valid_i),
    .wr_ready_o (fifo_ready),
    .rd_data_o  (fifo_data),
    .rd_valid_o (fifo_valid),
    .rd_ready_i (fifo_take),
    .level_o    (fifo_level)
  );

  // output register is free when empty or being drained this cycle
  assign out_free  = ~video_valid_o | video_ready_i;
  assign fifo_take = out_free;

  // video output register, so every output pin leaves a flip-flop
  always @(posedge mclk_i) begin
    if (!rstn_i) begin
      blue_video_out_o  <= 1'b0;
      red_video_out_o   <= 1'b0;
      green_video_out_o <= 1'b0;
      video_valid_o     <= 1'b0;
    end else if (out_free) begin
      video_valid_o <= fifo_valid;
      if (fifo_valid) begin
        blue_video_out_o  <= fifo_data[`CH_BLUE];
        red_video_out_o   <= fifo_data[`CH_RED];
        green_video_out_o <= fifo_data[`CH_GREEN];
      end
    end
  end

  // snapshot of the last accepted pixel's decode
  always @(posedge mclk_i) begin
    if (!rstn_i) begin
      last_invert_n  <= {`CH_N{1'b1}};
      last_force_n   <= {`CH_N{1'b1}};
      last_pres_on_n <= 1'b1;
      last_neutral   <= 1'b1;
    end else if (pix_take) begin
      last_invert_n  <= invert_n;
      last_force_n   <= force_n;
      last_pres_on_n <= presentation_on_n;
      last_neutral   <= neutral_sel;
    end
  end

  // accepted pixel counter, wraps silently; software clears it by write
  always @(posedge mclk_i) begin
    if (!rstn_i)
      pix_count <= {`PIXCNT_W{1'b0}};
    else if (reg_wr_i && reg_addr_i == `OFS_COUNT)
      pix_count <= {`PIXCNT_W{1'b0}};
    else if (pix_take)
      pix_count <= pix_count + {{(`PIXCNT_W-1){1'b0}}, 1'b1};
  end

  // control register write; bits above the field are ignored
  always @(posedge mclk_i) begin
    if (!rstn_i)
      ctrl <= `CTRL_RESET;
    else if (reg_wr_i && reg_addr_i == `OFS_CTRL)
      ctrl <= reg_wdata_i[`CTRL_W-1:0];
  end

  // read data stand one cycle after the strobe, zero otherwise
  always @(posedge mclk_i) begin
    if (!rstn_i) begin
      reg_rdata_o <= {`DATA_W{1'b0}};
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        `OFS_CTRL: begin
          reg_rdata_o <= {{(`DATA_W-`CTRL_W){1'b0}}, ctrl};
        end
        `OFS_STATUS: begin
          reg_rdata_o <= {{(`DATA_W-`ST_LEVEL_LO-`LEVEL_W){1'b0}}, fifo_level,
                          last_neutral, last_pres_on_n, last_force_n, last_invert_n};
        end
        `OFS_COUNT: begin
          reg_rdata_o <= pix_count;
        end
        default: begin
          reg_rdata_o <= {`DATA_W{1'b0}};
        end
      endcase
    end else begin
      reg_rdata_o <= {`DATA_W{1'b0}};
    end
  end

endmodule // colour_gate

// ---- colour_gate_assertions.sv ----
// port-level checker for the colour gate
`timescale 1ns/10ps
`include "colour_gate_defs.vh"
module colour_gate_checker (
  input wire logic        mclk_i,
  input wire logic        rstn_i,
  input wire logic [3:0]  reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic        reg_wr_i,
  input wire logic        reg_rd_i,
  input wire logic [31:0] reg_rdata_o,
  input wire logic        pix_valid_i,
  input wire logic        pix_ready_o,
  input wire logic [19:0] pix_bits,
  input wire logic [2:0]  vid,
  input wire logic        video_valid_o,
  input wire logic        video_ready_i
);
  import colour_ref_pkg::*;
  logic [2:0]  ctrl;
  logic [10:0] mem [0:15];
  logic [3:0]  wp;
  logic [3:0]  rp;
  logic [4:0]  cnt;
  logic [10:0] hd;
  logic        fin;
  logic        fout;

  // handshakes and the oldest pixel still in flight
  assign fin  = pix_valid_i & pix_ready_o;
  assign fout = video_valid_o & video_ready_i;
  assign hd   = mem[rp];

  // shadow of the control bits and of accepted pixels, in order
  always_ff @(posedge mclk_i) begin
    if (fin) begin
      mem[wp] <= ref_pix(ctrl, pix_bits);
    end
    if (!rstn_i) begin
      ctrl <= 3'h0;
      wp   <= 4'h0;
      rp   <= 4'h0;
      cnt  <= 5'h00;
    end else begin
      if (reg_wr_i && reg_addr_i == `OFS_CTRL) begin
        ctrl <= reg_wdata_i[2:0];
      end
      wp  <= wp + 4'(fin);
      rp  <= rp + 4'(fout);
      cnt <= cnt + 5'(fin) - 5'(fout);
    end
  end

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);

  property p_match; fout |-> vid == hd[2:0]; endproperty
  property p_force_on; fout |-> (vid & hd[5:3] & ~hd[8:6]) == (hd[5:3] & ~hd[8:6]); endproperty
  property p_force_off; fout |-> (vid & hd[5:3] & hd[8:6]) == 3'h0; endproperty
  property p_cov; fout && hd[10] |-> vid == 3'h7; endproperty
  property p_sweep0; fout && hd[9] |-> vid == 3'h1; endproperty
  property p_hold; video_valid_o && !video_ready_i |=> video_valid_o && $stable(vid); endproperty
  // empty pipe: two quiet edges, then the pixel within a short bound
  property p_latency;
    fin && cnt == 5'h00 |=> !video_valid_o [*2] ##[1:6] video_valid_o;
  endproperty
  property p_ctrl_rd; reg_rd_i && reg_addr_i == `OFS_CTRL |=> reg_rdata_o == 32'(ctrl); endproperty

  a_match: assert property (p_match) else $error("video differs from reference");
  a_force_on: assert property (p_force_on) else $error("forced channel not on");
  a_force_off: assert property (p_force_off) else $error("forced channel not off");
  a_cov: assert property (p_cov) else $error("covering cursor not inverted");
  a_sweep0: assert property (p_sweep0) else $error("sweep zero not blue only");
  a_hold: assert property (p_hold) else $error("video changed while stalled");
  a_latency: assert property (p_latency) else $error("pixel latency wrong");
  a_ctrl_rd: assert property (p_ctrl_rd) else $error("control readback wrong");

  c_cov: cover property (fout && hd[10]);
  c_sweep0: cover property (fout && hd[9]);
  c_full: cover property (pix_valid_i && !pix_ready_o);
endmodule // colour_gate_checker

bind colour_gate colour_gate_checker u_chk (.mclk_i(mclk_i), .rstn_i(rstn_i),
  .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
  .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .pix_valid_i(pix_valid_i),
  .pix_ready_o(pix_ready_o), .video_valid_o(video_valid_o), .video_ready_i(video_ready_i),
  .vid({green_video_out_o, red_video_out_o, blue_video_out_o}),
  .pix_bits({cg_green_video_i, cg_red_video_i, cg_blue_video_i, rom_green_block_sel_i,
    rom_red_block_sel_i, rom_blue_block_sel_i, video_on_n_i, triple_plane_i,
    cursor_position_i, vsync_load_n_i, display_enable_i, attr_green_n_i, attr_red_n_i,
    attr_blue_n_i, selector_mid_s_n_i, selector_mid_one_i, selector_mid_two_i,
    underline_sweep_flag_i, sweep_zero_flag_i, double_sweep_flag_i}));

// ---- colour_gate_defs.vh ----
// constants for the colour decoder and on/off gating block
`ifndef COLOUR_GATE_DEFS_VH
`define COLOUR_GATE_DEFS_VH

// register bus geometry
`define ADDR_W            4
`define DATA_W            32

// register byte offsets
`define OFS_CTRL          4'h0
`define OFS_STATUS        4'h4
`define OFS_COUNT         4'h8

// control register fields
`define CTRL_CURSOR_STYLE 0
`define CTRL_PRES_INHIBIT 1
`define CTRL_PRES_ENABLE  2
`define CTRL_W            3
`define CTRL_RESET        3'h0

// status register field positions
`define ST_INV_LO         0
`define ST_FORCE_LO       3
`define ST_PRES_ON_N      6
`define ST_NEUTRAL        7
`define ST_LEVEL_LO       8

// channel numbering inside the three-bit vectors
`define CH_BLUE           0
`define CH_RED            1
`define CH_GREEN          2
`define CH_N              3

// video fifo geometry
`define FIFO_DEPTH        8
`define FIFO_AW           3
`define LEVEL_W           4

// pixel counter width
`define PIXCNT_W          32

`endif

// ---- colour_gate_tb_top.sv ----
// self-checking bench for the colour gate
`timescale 1ns/10ps
`include "colour_gate_defs.vh"
module colour_gate_tb_top;
  import colour_ref_pkg::*;
  logic        mclk_i = 1'b0;
  logic        rstn_i = 1'b0;
  logic [3:0]  reg_addr_i = 4'h0;
  logic [31:0] reg_wdata_i = 32'h0000_0000;
  logic [31:0] reg_rdata_o;
  logic [31:0] rd;
  logic        reg_wr_i = 1'b0;
  logic        reg_rd_i = 1'b0;
  logic        pix_valid_i = 1'b0;
  logic        pix_ready_o;
  logic [19:0] pix = 20'h0_0000;
  logic [2:0]  vid;
  logic [2:0]  ctrl = 3'h0;
  logic [10:0] rv;
  logic        video_valid_o;
  logic        video_ready_i;
  logic        hold = 1'b0;
  logic        slow = 1'b0;
  logic        full = 1'b0;
  logic [31:0] rnd = 32'hc37b_74b3;
  logic [2:0]  exp_q[$];
  int          num_errors = 0;
  int          checks_done = 0;
  int          npix = 0;

  colour_gate DUT (.mclk_i(mclk_i), .rstn_i(rstn_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .pix_valid_i(pix_valid_i), .pix_ready_o(pix_ready_o),
    .double_sweep_flag_i(pix[0]), .sweep_zero_flag_i(pix[1]),
    .underline_sweep_flag_i(pix[2]), .selector_mid_two_i(pix[3]),
    .selector_mid_one_i(pix[4]), .selector_mid_s_n_i(pix[5]), .attr_blue_n_i(pix[6]),
    .attr_red_n_i(pix[7]), .attr_green_n_i(pix[8]), .display_enable_i(pix[9]),
    .vsync_load_n_i(pix[10]), .cursor_position_i(pix[11]), .triple_plane_i(pix[12]),
    .video_on_n_i(pix[13]), .rom_blue_block_sel_i(pix[14]),
    .rom_red_block_sel_i(pix[15]), .rom_green_block_sel_i(pix[16]),
    .cg_blue_video_i(pix[17]), .cg_red_video_i(pix[18]), .cg_green_video_i(pix[19]),
    .blue_video_out_o(vid[0]), .red_video_out_o(vid[1]), .green_video_out_o(vid[2]),
    .video_valid_o(video_valid_o), .video_ready_i(video_ready_i));

  monitor_sink u_sink (.mclk_i(mclk_i), .hold_i(hold), .slow_i(slow),
    .video_ready_o(video_ready_i));

  initial begin
    forever #4 mclk_i = ~mclk_i;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    reg_wr_i    <= 1'b1;
    @(posedge mclk_i);
    reg_wr_i    <= 1'b0;
    if (a == `OFS_CTRL) ctrl = d[2:0];
  endtask

  // read data stand only in the cycle after the strobe
  task automatic reg_rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge mclk_i);
    reg_addr_i <= a;
    reg_rd_i   <= 1'b1;
    @(posedge mclk_i);
    reg_rd_i   <= 1'b0;
    #1 d = reg_rdata_o;
  endtask

  // offers n random pixels, each held until taken; stop quits at a refusal
  task automatic send(input int n, input bit stop);
    for (int i = 0; i < n; i++) begin
      rnd = lfsr(rnd);
      pix         <= rnd[19:0];
      pix_valid_i <= 1'b1;
      do @(posedge mclk_i); while (!pix_ready_o && !stop);
      full = !pix_ready_o;
      if (full) break;
    end
    pix_valid_i <= 1'b0;
  endtask

  task automatic drain();
    for (int k = 0; k < 400 && exp_q.size() != 0; k++) @(posedge mclk_i);
    check("pixels left", 32'h0, 32'(exp_q.size()));
  endtask

  // reference model: queue pixels on acceptance, compare at every handover
  always @(posedge mclk_i) begin
    if (rstn_i && pix_valid_i && pix_ready_o) begin
      rv = ref_pix(ctrl, pix);
      exp_q.push_back(rv[2:0]);
      npix++;
    end
    if (rstn_i && video_valid_o && video_ready_i) begin
      check("video", 32'(exp_q.pop_front()), 32'(vid));
    end
  end

  task automatic results();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // hang guard, several times the expected run length
  initial begin
    #100000;
    num_errors++;
    results();
  end

  initial begin
    repeat (2) @(posedge mclk_i);
    rstn_i <= 1'b1;
    reg_rd(`OFS_STATUS, rd);
    check("status after reset", 32'h0000_00ff, rd);
    reg_rd(4'hc, rd);
    check("unmapped read", 32'h0000_0000, rd);
    reg_wr(`OFS_CTRL, 32'hffff_ffff);
    reg_rd(`OFS_CTRL, rd);
    check("control", 32'h0000_0007, rd);
    slow <= 1'b1;
    // every cursor style and presentation bit setting, slow monitor
    for (int c = 0; c < 8; c++) begin
      reg_wr(`OFS_CTRL, 32'(c));
      send(48, 1'b0);
      drain();
    end
    hold <= 1'b1;
    send(20, 1'b0 | 1'b1);
    check("refused when full", 32'h0000_0001, 32'(full));
    reg_rd(`OFS_STATUS, rd);
    check("fifo level when full", 32'h0000_0008, 32'(rd[11:8]));
    hold <= 1'b0;
    drain();
    reg_rd(`OFS_COUNT, rd);
    check("pixel count", 32'(npix), rd);
    reg_wr(`OFS_COUNT, 32'h0000_0000);
    reg_rd(`OFS_COUNT, rd);
    check("count cleared", 32'h0000_0000, rd);
    results();
  end
endmodule // colour_gate_tb_top

// ---- colour_ref_pkg.sv ----
// reference decode and gating of one character pixel
package colour_ref_pkg;

  // p: 0 dsw, 1 sw0, 2 usw, 3 mid_two, 4 mid_one, 5 mid_s_n, 6-8 attr_n b/r/g,
  // 9 de, 10 load_n, 11 cursor, 12 triple, 13 von_n, 14-16 block sel, 17-19 cg video
  // result: 10 covering cursor, 9 sweep zero, 8:6 invert_n, 5:3 force_n, 2:0 video
  function automatic logic [10:0] ref_pix(input logic [2:0] c, input logic [19:0] p);
    logic       pr;
    logic       bs;
    logic       nt;
    logic [2:0] at;
    logic [2:0] iv;
    logic [2:0] fc;
    logic [2:0] sl;
    logic [2:0] sr;
    begin
      pr = p[9] & ~c[1] & c[2] & ~p[10];
      bs = pr & ~p[0] & ~p[1];
      at = ~p[8:6];
      iv = ~({3{bs & p[11] & ~c[0]}} | {3{bs & ~p[3] & ~p[4]}} & at);
      iv[0] = iv[0] & ~(pr & ~p[0] & p[1]);
      fc = ~({3{bs & ~p[2] & p[5] & (~p[11] | c[0])}} & at);
      nt = ~(p[12] & ~p[13]);
      sl = nt ? p[16:14] : 3'h7;
      sr = nt ? {3{|(p[19:17] & sl)}} : p[19:17] & sl;
      // forced channels ignore the video source entirely
      return {bs & p[11] & ~c[0], pr & ~p[0] & p[1], iv, fc,
              (fc & ~iv) | (~fc & (sr ^ iv))};
    end
  endfunction

endpackage

// ---- monitor_sink.sv ----
// monitor-side sink: takes gated video, stalls on command or at random
`timescale 1ns/10ps
module monitor_sink (
  input  wire logic mclk_i,
  input  wire logic hold_i,
  input  wire logic slow_i,
  output logic      video_ready_o
);
  logic [7:0] rnd = 8'ha5;

  initial video_ready_o = 1'b0;

  // ready moves only just after an edge; a slow monitor drops it often
  always @(posedge mclk_i) begin
    rnd           <= {rnd[6:0], rnd[7] ^ rnd[5] ^ rnd[4] ^ rnd[3]};
    video_ready_o <= !hold_i && (!slow_i || rnd[0]);
  end
endmodule // monitor_sink

// ---- video_fifo.v ----
// small synchronous fifo with registered read data and registered flags
`timescale 1ns/10ps
module video_fifo #(
  parameter WIDTH = 3,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  input  wire             mclk_i,
  input  wire             rstn_i,
  input  wire [WIDTH-1:0] wr_data_i,
  input  wire             wr_valid_i,
  output reg              wr_ready_o,
  output reg  [WIDTH-1:0] rd_data_o,
  output reg              rd_valid_o,
  input  wire             rd_ready_i,
  output reg  [AW:0]      level_o
);

  // full mark at the counter's width, so the compare below drops no bits
  localparam [AW:0] FULL_MARK = DEPTH;

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr;
  reg [AW-1:0]    rd_ptr;
  reg [AW:0]      count;
  reg [AW:0]      next_count;
  wire            push;
  wire            pop;
  wire            stage_free;

  // output register refills whenever it is empty or being taken and the array holds data
  assign stage_free = ~rd_valid_o | rd_ready_i;
  assign push       = wr_valid_i & wr_ready_o;
  assign pop        = stage_free & (count != {(AW+1){1'b0}});

  // occupancy of the storage array, not counting the output register
  always @* begin
    next_count = count;
    if (push & ~pop)
      next_count = count + {{AW{1'b0}}, 1'b1};
    else if (pop & ~push)
      next_count = count - {{AW{1'b0}}, 1'b1};
  end

  // storage array needs no reset, pointers guard its contents
  always @(posedge mclk_i) begin
    if (push)
      mem[wr_ptr] <= wr_data_i;
  end

  // pointers, flags and the read register
  always @(posedge mclk_i) begin
    if (!rstn_i) begin
      wr_ptr     <= {AW{1'b0}};
      rd_ptr     <= {AW{1'b0}};
      count      <= {(AW+1){1'b0}};
      wr_ready_o <= 1'b0;
      rd_valid_o <= 1'b0;
      rd_data_o  <= {WIDTH{1'b0}};
      level_o    <= {(AW+1){1'b0}};
    end else begin
      if (push)
        wr_ptr <= wr_ptr + {{(AW-1){1'b0}}, 1'b1};
      if (pop) begin
        rd_ptr     <= rd_ptr + {{(AW-1){1'b0}}, 1'b1};
        rd_data_o  <= mem[rd_ptr];
        rd_valid_o <= 1'b1;
      end else if (rd_ready_i) begin
        rd_valid_o <= 1'b0;
      end
      count      <= next_count;
      level_o    <= next_count;
      // registered full flag: ready only with a free slot next cycle
      wr_ready_o <= (next_count != FULL_MARK);
    end
  end

endmodule // video_fifo
